// ---- src/dhpwm_pkg.sv ----
package dhpwm_pkg;

  // Register word offsets (byte addresses = 4 * index)
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_DUTY_H = 4'h1;
  localparam logic [3:0] OFS_DUTY_L = 4'h2;
  localparam logic [3:0] OFS_PER_H  = 4'h3;
  localparam logic [3:0] OFS_PER_L  = 4'h4;
  localparam logic [3:0] OFS_DEAD   = 4'h5;
  localparam logic [3:0] OFS_TB_H   = 4'h6;
  localparam logic [3:0] OFS_TB_L   = 4'h7;
  localparam logic [3:0] OFS_DCR    = 4'h8;

  // Control register bit positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_MODE  = 1;
  localparam int CTRL_SHUTDOWN_PIN_ENABLE = 2;
  localparam int CTRL_SHUTDOWN_IRQ_ENABLE = 3;
  localparam int CTRL_FLAG  = 4;
  localparam int CTRL_LVL   = 5;

  // Dither control register
  localparam int DCR_CLK = 3;

  localparam logic [15:0] RST_WORD16 = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [2:0]  SEL_MAX    = 3'h5;

  typedef struct packed {
    logic        enable;
    logic        mode;
    logic        pin_en;
    logic        irq_en;
  } dhpwm_ctrl_s;

  typedef enum logic [1:0] {
    DHPWM_IDLE = 2'b00,
    DHPWM_RUN  = 2'b01
  } dhpwm_state_e;

endpackage : dhpwm_pkg

// ---- src/dhpwm_deadtime.sv ----
`timescale 1ns/1ps
module dhpwm_deadtime (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       raw_in,
  input  wire logic [7:0] dead_cnt,
  output logic            dly_out
);
  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;

  // Counts high time; output rises once count reaches deadtime
  assign cnt_next = raw_in ? ((cnt_reg[8]) ? cnt_reg : cnt_reg + 9'h001)
                           : 9'h000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= 9'h000;
      dly_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dly_out <= raw_in && (cnt_reg >= {1'b0, dead_cnt});
    end
  end
endmodule : dhpwm_deadtime

// ---- src/dhpwm_top.sv ----
// Notes on behaviour
// - Mode 0: variable period, half duty
// - Base period P, long period P+1
// - Period low bits give long-period step count
// - Mode 1: same period for both waveforms
// - Base duty DC, long duty DC+1
// - Duty low bits give long-duty step count
// - Five-bit modulus counter compared with fraction
// - Select code sets steps and divisor
// - Fraction is step shifted right, truncated
// - Fraction source follows mode bit
// - Dither counter advances from cycle or timebase
// - Clock choice 1 timebase, 0 cycle end
// - Cycle clocking: one step per period
// - Rising edges delayed by deadtime
// - Large deadtime keeps low side off
// - Large deadtime keeps high side off
// - Enabled shutdown low sets flag, interrupt
// - Request holds until cleared and pin high
// - Shutdown low forces outputs off, disables
// - High byte latched until low written
// - Wait: runs, registers blocked, irq wakes
// - Stop: outputs low, enable cleared
// - Shutdown detection alive during stop
// - Break protects flag unless clear enabled
`timescale 1ns/1ps
module dhpwm_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        fault_shutdown_in,
  input  wire logic        cpu_wait,
  input  wire logic        cpu_stop,
  input  wire logic        debug_break,
  input  wire logic        break_clear_enable,
  output logic             high_side_out,
  output logic             low_side_out,
  output logic             shutdown_irq
);

  // Synchronised pin level
  logic sd_meta_reg;
  logic sd_sync_reg;
  logic sd_prev_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sd_meta_reg <= 1'b1;
      sd_sync_reg <= 1'b1;
      sd_prev_reg <= 1'b1;
    end else begin
      sd_meta_reg <= fault_shutdown_in;
      sd_sync_reg <= sd_meta_reg;
      sd_prev_reg <= sd_sync_reg;
    end
  end

  // Register file
  dhpwm_pkg::dhpwm_ctrl_s ctrl_reg;
  logic        flag_reg;
  logic [15:0] duty_word_reg;
  logic [15:0] per_word_reg;
  logic [15:0] tb_word_reg;
  logic [7:0]  hi_latch_duty_reg;
  logic [7:0]  hi_latch_per_reg;
  logic [7:0]  hi_latch_tb_reg;
  logic [7:0]  deadtime_count;
  logic        dither_clock_choice;
  logic [2:0]  sel_reg;
  logic        ack_reg;

  // One wait state; blocked completely in wait state
  wire req       = (avs_read || avs_write) && !cpu_wait;
  wire wr_go     = avs_write && req && !ack_reg;
  wire rd_go     = avs_read && req && !ack_reg;
  wire wr_ctrl   = wr_go && (avs_address == dhpwm_pkg::OFS_CTRL);
  wire wr_duty_h = wr_go && (avs_address == dhpwm_pkg::OFS_DUTY_H);
  wire wr_duty_l = wr_go && (avs_address == dhpwm_pkg::OFS_DUTY_L);
  wire wr_per_h  = wr_go && (avs_address == dhpwm_pkg::OFS_PER_H);
  wire wr_per_l  = wr_go && (avs_address == dhpwm_pkg::OFS_PER_L);
  wire wr_dead   = wr_go && (avs_address == dhpwm_pkg::OFS_DEAD);
  wire wr_tb_h   = wr_go && (avs_address == dhpwm_pkg::OFS_TB_H);
  wire wr_tb_l   = wr_go && (avs_address == dhpwm_pkg::OFS_TB_L);
  wire wr_dcr    = wr_go && (avs_address == dhpwm_pkg::OFS_DCR);
  wire [7:0] wbyte = avs_writedata[7:0];

  // Shutdown detection, active during stop as well
  wire sd_low   = ctrl_reg.pin_en && !sd_sync_reg;
  wire sd_fall  = ctrl_reg.pin_en && sd_prev_reg && !sd_sync_reg;
  wire sd_event = sd_low || sd_fall;
  wire clr_ok   = !debug_break || break_clear_enable;
  wire flag_clr = wr_ctrl && !wbyte[dhpwm_pkg::CTRL_FLAG] && clr_ok;
  // Set wins over clear; low pin keeps it pending
  wire flag_next = sd_event ? 1'b1 : (flag_clr ? 1'b0 : flag_reg);
  wire en_kill   = sd_event || cpu_stop;
  wire en_wr     = wr_ctrl ? wbyte[dhpwm_pkg::CTRL_EN] : ctrl_reg.enable;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= '0;
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      if (wr_ctrl) begin
        ctrl_reg.mode   <= wbyte[dhpwm_pkg::CTRL_MODE];
        ctrl_reg.pin_en <= wbyte[dhpwm_pkg::CTRL_SHUTDOWN_PIN_ENABLE];
        ctrl_reg.irq_en <= wbyte[dhpwm_pkg::CTRL_SHUTDOWN_IRQ_ENABLE];
      end
      ctrl_reg.enable <= en_kill ? 1'b0 : en_wr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      duty_word_reg     <= dhpwm_pkg::RST_WORD16;
      per_word_reg      <= dhpwm_pkg::RST_WORD16;
      tb_word_reg       <= dhpwm_pkg::RST_WORD16;
      hi_latch_duty_reg <= dhpwm_pkg::RST_BYTE;
      hi_latch_per_reg  <= dhpwm_pkg::RST_BYTE;
      hi_latch_tb_reg   <= dhpwm_pkg::RST_BYTE;
      deadtime_count    <= dhpwm_pkg::RST_BYTE;
      dither_clock_choice <= 1'b0;
      sel_reg           <= 3'h0;
    end else begin
      if (wr_duty_h) hi_latch_duty_reg <= wbyte;
      if (wr_per_h)  hi_latch_per_reg  <= wbyte;
      if (wr_tb_h)   hi_latch_tb_reg   <= wbyte;
      if (wr_duty_l) duty_word_reg <= {hi_latch_duty_reg, wbyte};
      if (wr_per_l)  per_word_reg  <= {hi_latch_per_reg, wbyte};
      if (wr_tb_l)   tb_word_reg   <= {hi_latch_tb_reg, wbyte};
      if (wr_dead)   deadtime_count <= wbyte;
      if (wr_dcr) begin
        dither_clock_choice <= wbyte[dhpwm_pkg::DCR_CLK];
        sel_reg             <= wbyte[2:0];
      end
    end
  end

  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (avs_address)
      dhpwm_pkg::OFS_CTRL: rd_mux = {2'b00, sd_sync_reg, flag_reg,
                                     ctrl_reg.irq_en, ctrl_reg.pin_en,
                                     ctrl_reg.mode, ctrl_reg.enable};
      dhpwm_pkg::OFS_DUTY_H: rd_mux = duty_word_reg[15:8];
      dhpwm_pkg::OFS_DUTY_L: rd_mux = duty_word_reg[7:0];
      dhpwm_pkg::OFS_PER_H:  rd_mux = per_word_reg[15:8];
      dhpwm_pkg::OFS_PER_L:  rd_mux = per_word_reg[7:0];
      dhpwm_pkg::OFS_DEAD:   rd_mux = deadtime_count;
      dhpwm_pkg::OFS_TB_H:   rd_mux = tb_word_reg[15:8];
      dhpwm_pkg::OFS_TB_L:   rd_mux = tb_word_reg[7:0];
      dhpwm_pkg::OFS_DCR:    rd_mux = {4'h0, dither_clock_choice, sel_reg};
      default:               rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      ack_reg         <= req && !ack_reg;
      avs_waitrequest <= !(req && !ack_reg);
      if (rd_go) avs_readdata <= {24'h000000, rd_mux};
    end
  end

  // Waveform parameters
  wire dither_mode_select = ctrl_reg.mode;
  wire [10:0] p_val      = per_word_reg[15:5];
  wire [10:0] duty_value = duty_word_reg[15:5];
  wire [4:0] step_raw = dither_mode_select ? duty_word_reg[4:0]
                                           : per_word_reg[4:0];
  wire [2:0] sel_eff = (sel_reg > dhpwm_pkg::SEL_MAX) ? dhpwm_pkg::SEL_MAX
                                                      : sel_reg;
  wire [4:0] step_scaled = step_raw >> sel_eff;
  // Modulus = 32 >> sel, 0 steps for code 5
  wire [5:0] modulus = 6'h20 >> sel_eff;
  wire [11:0] base_period = {1'b0, p_val};
  wire [11:0] long_period = dither_mode_select ? {1'b0, p_val}
                                               : {1'b0, p_val} + 12'h001;
  wire [11:0] base_duty = dither_mode_select ? {1'b0, duty_value}
                                             : {2'b00, p_val[10:1]};
  wire [11:0] long_duty = dither_mode_select ? {1'b0, duty_value} + 12'h001
                                             : long_period >> 1;

  // Dither counter and timebase
  logic [4:0]  dith_cnt_reg;
  logic [15:0] tb_cnt_reg;
  logic [11:0] pcnt_reg;
  logic [11:0] cur_per_reg;
  logic [11:0] cur_duty_reg;
  logic        raw_reg;

  wire running   = ctrl_reg.enable;
  wire cyc_end   = running && (pcnt_reg + 12'h001 >= cur_per_reg);
  wire tb_tick   = running && (tb_cnt_reg + 16'h0001 >= tb_word_reg);
  wire dith_tick = dither_clock_choice ? tb_tick : cyc_end;
  wire [5:0] dith_inc = {1'b0, dith_cnt_reg} + 6'h01;
  wire [4:0] dith_next = (dith_inc >= modulus) ? 5'h00 : dith_inc[4:0];
  wire use_long = (dith_cnt_reg < step_scaled);
  wire [11:0] sel_per  = use_long ? long_period : base_period;
  wire [11:0] sel_duty = use_long ? long_duty : base_duty;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dith_cnt_reg <= 5'h00;
      tb_cnt_reg   <= 16'h0000;
    end else if (!running) begin
      dith_cnt_reg <= 5'h00;
      tb_cnt_reg   <= 16'h0000;
    end else begin
      tb_cnt_reg <= tb_tick ? 16'h0000 : tb_cnt_reg + 16'h0001;
      if (dith_tick) dith_cnt_reg <= dith_next;
    end
  end

  // Period counter; new values load at cycle boundary
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pcnt_reg     <= 12'h000;
      cur_per_reg  <= 12'h000;
      cur_duty_reg <= 12'h000;
      raw_reg      <= 1'b0;
    end else if (!running) begin
      pcnt_reg     <= 12'h000;
      cur_per_reg  <= sel_per;
      cur_duty_reg <= sel_duty;
      // First cycle after enable starts in its duty part
      raw_reg      <= (sel_duty != 12'h000);
    end else if (cyc_end) begin
      pcnt_reg     <= 12'h000;
      cur_per_reg  <= sel_per;
      cur_duty_reg <= sel_duty;
      raw_reg      <= (sel_duty != 12'h000);
    end else begin
      pcnt_reg <= pcnt_reg + 12'h001;
      raw_reg  <= (pcnt_reg + 12'h001 < cur_duty_reg);
    end
  end

  // Duty part drives the low side; high side gets the rest
  wire top_raw = running && !raw_reg;
  wire bot_raw = running && raw_reg;
  logic top_dly;
  logic bot_dly;

  dhpwm_deadtime u_dead_top (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .raw_in   (top_raw),
    .dead_cnt (deadtime_count),
    .dly_out  (top_dly)
  );

  dhpwm_deadtime u_dead_bot (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .raw_in   (bot_raw),
    .dead_cnt (deadtime_count),
    .dly_out  (bot_dly)
  );

  wire force_off = !running || sd_event || cpu_stop;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_side_out <= 1'b0;
      low_side_out  <= 1'b0;
      shutdown_irq  <= 1'b0;
    end else begin
      high_side_out <= top_dly && !force_off;
      low_side_out  <= bot_dly && !force_off;
      shutdown_irq  <= flag_next && ctrl_reg.irq_en;
    end
  end

endmodule : dhpwm_top

// ---- test/dhpwm_assertions.sv ----
`timescale 1ns/1ps
module dhpwm_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        fault_shutdown_in,
  input wire logic        cpu_wait,
  input wire logic        cpu_stop,
  input wire logic        debug_break,
  input wire logic        break_clear_enable,
  input wire logic        high_side_out,
  input wire logic        low_side_out,
  input wire logic        shutdown_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest && !cpu_wait;
  endsequence
  sequence s_fault;
    !fault_shutdown_in [*5] ##0 shutdown_irq;
  endsequence
  ack_answer_a: assert property (s_take |=> !avs_waitrequest)
    else $error("Access not answered");
  ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Answer longer than one cycle");
  rd_upper_a: assert property (!avs_waitrequest && avs_read
    |-> avs_readdata[31:8] == 24'h000000)
    else $error("Read data upper bits set");
  wait_block_a: assert property (cpu_wait && $past(cpu_wait)
    |-> avs_waitrequest) else $error("Access during wait");
  stop_off_a: assert property (cpu_stop [*3]
    |-> !high_side_out && !low_side_out) else $error("Outputs on in stop");
  no_overlap_a: assert property (!(high_side_out && low_side_out))
    else $error("Both outputs high");
  irq_hold_a: assert property (s_fault |=> shutdown_irq)
    else $error("Request dropped while pin low");
  fault_off_a: assert property (s_fault
    |-> !high_side_out && !low_side_out) else $error("Outputs on in fault");
  brk_keep_a: assert property (debug_break && !break_clear_enable
    && shutdown_irq |=> shutdown_irq) else $error("Flag cleared in break");
endmodule : dhpwm_assertions

bind dhpwm_top dhpwm_assertions u_chk (.sys_clk, .rst, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .fault_shutdown_in,
  .cpu_wait, .cpu_stop, .debug_break, .break_clear_enable,
  .high_side_out, .low_side_out, .shutdown_irq);

// ---- test/dhpwm_stage_model.sv ----
`timescale 1ns/1ps
module dhpwm_stage_model (
  input wire logic sys_clk,
  input wire logic fault_cmd,
  input wire logic high_side_out,
  input wire logic low_side_out,
  output logic     fault_shutdown_in,
  output int       overlap
);
  initial begin
    fault_shutdown_in = 1'b1;
    overlap = 0;
  end
  // Sensor pulls the pin high again once the fault is gone
  always @(posedge sys_clk) begin
    fault_shutdown_in <= !fault_cmd;
    if (high_side_out && low_side_out)
      overlap <= overlap + 1;
  end
endmodule : dhpwm_stage_model

// ---- test/dhpwm_top_test.sv ----
`timescale 1ns/1ps
module dhpwm_top_test;
  logic        sys_clk, rst, avs_read, avs_write, cpu_wait, cpu_stop;
  logic        debug_break, break_clear_enable, fault_cmd;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        avs_waitrequest, fault_shutdown_in;
  logic        high_side_out, low_side_out, shutdown_irq;
  int          n_fail, tests_run, ov, a, b;
  realtime     t0;
  dhpwm_top uut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .fault_shutdown_in,
    .cpu_wait, .cpu_stop, .debug_break, .break_clear_enable,
    .high_side_out, .low_side_out, .shutdown_irq);
  dhpwm_stage_model stage (.sys_clk, .fault_cmd, .high_side_out,
    .low_side_out, .fault_shutdown_in, .overlap(ov));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task bus(input logic wr, input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= ad;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task setup(input logic [15:0] p, dc, input logic [7:0] dt, dcr, ct);
    bus(1'b1, dhpwm_pkg::OFS_PER_H, p[15:8]);
    bus(1'b1, dhpwm_pkg::OFS_PER_L, p[7:0]);
    bus(1'b1, dhpwm_pkg::OFS_DUTY_H, dc[15:8]);
    bus(1'b1, dhpwm_pkg::OFS_DUTY_L, dc[7:0]);
    bus(1'b1, dhpwm_pkg::OFS_DEAD, dt);
    bus(1'b1, dhpwm_pkg::OFS_DCR, dcr);
    bus(1'b1, dhpwm_pkg::OFS_CTRL, ct);
  endtask : setup
  // Clock cycles spanned by n high side periods
  task span(input int n);
    @(posedge high_side_out);
    t0 = $realtime;
    repeat (n) @(posedge high_side_out);
    a = int'(($realtime - t0) / 40.0);
  endtask : span
  task hcount(input int n);
    a = 0;
    b = 0;
    repeat (n) begin
      @(posedge sys_clk);
      a += int'(high_side_out);
      b += int'(low_side_out);
    end
  endtask : hcount
  task t_regs;
    bus(1'b0, dhpwm_pkg::OFS_CTRL, 8'h00);
    chk(rd[4:0], 32'h0);
    bus(1'b0, 4'h9, 8'h00);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task t_freq;
    for (int s = 0; s < 6; s++) begin
      setup(16'h029F, 16'h0000, 8'h00, 8'(s), 8'h01);
      cyc(900);
      span(32 >> s);
      chk(a, (32 >> s) * 20 + (31 >> s));
    end
    setup(16'h0280, 16'h0000, 8'h03, 8'h00, 8'h01);
    cyc(100);
    hcount(200);
    chk(a, 70);
    chk(b, 70);
    $display("t_freq done");
  endtask : t_freq
  task t_duty;
    setup(16'h029F, 16'h00B7, 8'h00, 8'h01, 8'h03);
    cyc(700);
    hcount(320);
    chk(b, 91);
    chk(a, 229);
    span(16);
    chk(a, 320);
    for (int i = 0; i < 2; i++) begin
      setup(16'h0280, i ? 16'h01E0 : 16'h00A0, 8'h05, 8'h05, 8'h03);
      cyc(100);
      hcount(200);
      chk(a, i ? 0 : 100);
      chk(b, i ? 100 : 0);
    end
    $display("t_duty done");
  endtask : t_duty
  task t_latch;
    setup(16'h0280, 16'h0000, 8'h00, 8'h05, 8'h01);
    cyc(100);
    bus(1'b1, dhpwm_pkg::OFS_PER_H, 8'h05);
    cyc(100);
    span(4);
    chk(a, 80);
    bus(1'b1, dhpwm_pkg::OFS_PER_L, 8'h00);
    cyc(200);
    span(4);
    chk(a, 160);
    $display("t_latch done");
  endtask : t_latch
  task t_tbase;
    setup(16'h0280, 16'h00B0, 8'h00, 8'h0C, 8'h02);
    bus(1'b1, dhpwm_pkg::OFS_TB_H, 8'hFF);
    bus(1'b1, dhpwm_pkg::OFS_TB_L, 8'hFF);
    bus(1'b1, dhpwm_pkg::OFS_CTRL, 8'h03);
    cyc(60);
    hcount(200);
    chk(b, 60);
    chk(a, 140);
    bus(1'b1, dhpwm_pkg::OFS_TB_H, 8'h00);
    bus(1'b1, dhpwm_pkg::OFS_TB_L, 8'h14);
    cyc(60);
    hcount(200);
    chk(b, 55);
    $display("t_tbase done");
  endtask : t_tbase
  task t_shut;
    setup(16'h0280, 16'h0000, 8'h00, 8'h05, 8'h0D);
    cyc(50);
    fault_cmd <= 1'b1;
    cyc(10);
    hcount(20);
    chk(a + b, 0);
    chk(shutdown_irq, 1);
    bus(1'b0, dhpwm_pkg::OFS_CTRL, 8'h00);
    chk(rd[4:0], 32'h1C);
    bus(1'b1, dhpwm_pkg::OFS_CTRL, 8'h0C);
    cyc(5);
    chk(shutdown_irq, 1);
    fault_cmd <= 1'b0;
    cyc(10);
    chk(shutdown_irq, 1);
    debug_break <= 1'b1;
    bus(1'b1, dhpwm_pkg::OFS_CTRL, 8'h0C);
    cyc(5);
    chk(shutdown_irq, 1);
    break_clear_enable <= 1'b1;
    bus(1'b1, dhpwm_pkg::OFS_CTRL, 8'h0C);
    cyc(5);
    debug_break <= 1'b0;
    break_clear_enable <= 1'b0;
    cyc(5);
    chk(shutdown_irq, 0);
    $display("t_shut done");
  endtask : t_shut
  task t_stop;
    bus(1'b1, dhpwm_pkg::OFS_CTRL, 8'h0D);
    cpu_stop <= 1'b1;
    cyc(10);
    hcount(40);
    chk(a + b, 0);
    fault_cmd <= 1'b1;
    cyc(10);
    chk(shutdown_irq, 1);
    cpu_stop <= 1'b0;
    fault_cmd <= 1'b0;
    cyc(10);
    bus(1'b0, dhpwm_pkg::OFS_CTRL, 8'h00);
    chk(rd[0], 0);
    bus(1'b1, dhpwm_pkg::OFS_CTRL, 8'h01);
    cpu_wait <= 1'b1;
    fork
      bus(1'b0, dhpwm_pkg::OFS_CTRL, 8'h00);
      begin
        cyc(20);
        chk(avs_waitrequest, 1);
        hcount(40);
        chk(a, 20);
        cpu_wait <= 1'b0;
      end
    join
    chk(rd[4:0], 32'h01);
    chk(ov, 0);
    $display("t_stop done");
  endtask : t_stop
  initial begin
    cyc(40000);
    n_fail++;
    complete_run;
  end
  initial begin
    {rst, avs_read, avs_write, cpu_wait, cpu_stop} = 5'h10;
    {debug_break, break_clear_enable, fault_cmd} = 3'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    cyc(4);
    rst <= 1'b0;
    t_regs;
    t_freq;
    t_duty;
    t_latch;
    t_tbase;
    t_shut;
    t_stop;
    complete_run;
  end
endmodule : dhpwm_top_test
